// ==== logic/nand_bad_block_management.sv ====
// device-side bad-block marking, status byte and ecc fail reporting
`timescale 1ns/10ps

// Function
// - bad marker readable from every page
// - between 1004 and 1024 usable blocks; valid_blocks has no lower limit at 1004, MIN_VALID is unused
// - bad block never affects good blocks
// - eight errors corrected, nine uncorrectable
// - status command drives status byte out
// - fail bit valid only when ready
module nand_bad_block_management (
    // clock and reset
    input  wire logic                                  clk,
    input  wire logic                                  resetn,
    // factory marking load, one block per strobe
    input  wire logic                                  mark_we,
    input  wire logic [nand_bbm_pkg::BLOCK_W-1:0]      mark_block,
    input  wire logic                                  mark_bad,
    // command and operation requests from the command decoder
    input  wire logic                                  cmd_valid,
    input  wire logic [7:0]                            cmd_code,
    input  wire logic                                  op_start,
    input  wire logic [nand_bbm_pkg::BLOCK_W-1:0]      op_block,
    input  wire logic                                  op_fail,
    // column read of a page in any block
    input  wire logic                                  col_rd,
    input  wire logic [nand_bbm_pkg::BLOCK_W-1:0]      col_block,
    input  wire logic [7:0]                            col_cell,
    // ecc result per 528-byte unit
    input  wire logic                                  ecc_valid,
    input  wire logic [nand_bbm_pkg::ERR_W-1:0]        ecc_errs,
    // write protect pin, active low
    input  wire logic                                  wp_n,
    // outputs
    output logic [7:0]                                 data_out,
    output logic                                       data_oe,
    output logic                                       ready,
    output logic                                       ecc_uncorr,
    output logic [nand_bbm_pkg::CNT_W-1:0]             valid_blocks
);
    logic [nand_bbm_pkg::NUM_BLOCKS-1:0] bad_q;
    logic [nand_bbm_pkg::CNT_W-1:0]      bad_cnt_q;
    logic [2:0]                          busy_q;
    logic                                fail_q;
    logic                                stat_mode_q;
    logic                                wp_s1_q;
    logic                                wp_s2_q;
    logic                                ecc_bad;
    logic                                op_go;

    // wp pin synchroniser
    always_ff @(posedge clk) begin
        if (!resetn) begin
            wp_s1_q <= 1'b0;
            wp_s2_q <= 1'b0;
        end else begin
            wp_s1_q <= wp_n;
            wp_s2_q <= wp_s1_q;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            bad_cnt_q <= '0;
        end else if (mark_we && mark_bad && !bad_q[mark_block]) begin
            bad_cnt_q <= bad_cnt_q + nand_bbm_pkg::CNT_W'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (mark_we) begin
            bad_q[mark_block] <= mark_bad;
        end
    end

    assign valid_blocks = nand_bbm_pkg::CNT_W'(nand_bbm_pkg::NUM_BLOCKS) - bad_cnt_q;

    // operations under protect or while busy do not run; a bad-block operation runs and sets fail
    assign op_go = op_start && (busy_q == nand_bbm_pkg::BUSY_RST) && wp_s2_q;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            busy_q <= nand_bbm_pkg::BUSY_RST;
        end else if (op_go) begin
            busy_q <= 3'(nand_bbm_pkg::BUSY_CYCLES);
        end else if (busy_q != nand_bbm_pkg::BUSY_RST) begin
            busy_q <= busy_q - 3'h1;
        end
    end

    assign ready = (busy_q == nand_bbm_pkg::BUSY_RST);

    // nine or more errors are uncorrectable
    assign ecc_bad = ecc_valid && (ecc_errs > nand_bbm_pkg::ERR_W'(nand_bbm_pkg::ECC_LIMIT));

    always_ff @(posedge clk) begin
        if (!resetn) begin
            fail_q     <= 1'b0;
            ecc_uncorr <= 1'b0;
        end else begin
            if (op_go) begin
                fail_q <= op_fail || bad_q[op_block];
            end else if (ecc_valid) begin
                fail_q <= ecc_bad;
            end
            if (ecc_valid) begin
                ecc_uncorr <= ecc_bad;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            stat_mode_q <= 1'b0;
        end else if (cmd_valid) begin
            stat_mode_q <= (cmd_code == nand_bbm_pkg::CMD_STATUS);
        end
    end

    // bad blocks isolated, marker byte on column read
    always_ff @(posedge clk) begin
        if (!resetn) begin
            data_out <= 8'h00;
            data_oe  <= 1'b0;
        end else if (stat_mode_q) begin
            data_oe  <= 1'b1;
            data_out <= 8'h00;
            data_out[nand_bbm_pkg::STAT_FAIL_BIT] <= ready && fail_q;
            data_out[nand_bbm_pkg::STAT_RDY1_BIT] <= ready;
            data_out[nand_bbm_pkg::STAT_RDY2_BIT] <= ready;
            data_out[nand_bbm_pkg::STAT_WP_BIT]   <= wp_s2_q;
        end else if (col_rd) begin
            data_oe  <= 1'b1;
            data_out <= bad_q[col_block] ? nand_bbm_pkg::BAD_MARK : col_cell;
        end else begin
            data_oe  <= 1'b0;
        end
    end

    a_fail_when_busy: assert property (@(posedge clk) disable iff (!resetn)
        (stat_mode_q && !ready) |=> !data_out[nand_bbm_pkg::STAT_FAIL_BIT])
        else $error("fail bit shown while busy");

    a_status_drive: assert property (@(posedge clk) disable iff (!resetn)
        (cmd_valid && cmd_code == nand_bbm_pkg::CMD_STATUS) |=> ##1 data_oe)
        else $error("status byte not driven");

    a_bad_mark_zero: assert property (@(posedge clk) disable iff (!resetn)
        (!stat_mode_q && col_rd && bad_q[col_block]) |=> data_out == nand_bbm_pkg::BAD_MARK)
        else $error("bad block column not zero");

    a_ecc_limit: assert property (@(posedge clk) disable iff (!resetn)
        ecc_valid |=> ecc_uncorr == ($past(ecc_errs) > 4'h8))
        else $error("ecc limit wrong");

    a_count_range: assert property (@(posedge clk) disable iff (!resetn)
        valid_blocks <= 11'(nand_bbm_pkg::NUM_BLOCKS))
        else $error("valid block count out of range");

    a_busy_len: assert property (@(posedge clk) disable iff (!resetn)
        op_go |=> !ready [*4] ##1 ready)
        else $error("busy length wrong");

    a_good_col_pass: assert property (@(posedge clk) disable iff (!resetn)
        (!stat_mode_q && col_rd && !bad_q[col_block]) |=> data_out == $past(col_cell))
        else $error("good block column altered");

    a_col_drive: assert property (@(posedge clk) disable iff (!resetn)
        (!stat_mode_q && col_rd) |=> data_oe)
        else $error("column read not driven");

    a_ready_bits: assert property (@(posedge clk) disable iff (!resetn)
        stat_mode_q |=> (data_out[5] == $past(ready)) && (data_out[6] == $past(ready)))
        else $error("ready bits wrong");

    a_protect_bit: assert property (@(posedge clk) disable iff (!resetn)
        stat_mode_q |=> data_out[7] == $past(wp_s2_q))
        else $error("protect bit wrong");

    a_fail_ready: assert property (@(posedge clk) disable iff (!resetn)
        (stat_mode_q && ready) |=> data_out[0] == $past(fail_q))
        else $error("fail bit lost while ready");

    a_oe_idle: assert property (@(posedge clk) disable iff (!resetn)
        (!stat_mode_q && !col_rd) |=> !data_oe)
        else $error("port driven while idle");

    // count drops per new bad block
    a_count_step: assert property (@(posedge clk) disable iff (!resetn)
        (mark_we && mark_bad && !bad_q[mark_block]) |=> valid_blocks == $past(valid_blocks) - 11'h1)
        else $error("valid block count step wrong");

    a_ecc_hold: assert property (@(posedge clk) disable iff (!resetn)
        !ecc_valid |=> $stable(ecc_uncorr))
        else $error("ecc result changed without unit");

    a_bad_op_fail: assert property (@(posedge clk) disable iff (!resetn)
        (op_go && bad_q[op_block]) |=> fail_q)
        else $error("bad block operation passed");
endmodule

// ==== pkg/nand_bbm_pkg.sv ====
// constants for the device-side bad-block and failure status logic
package nand_bbm_pkg;
    localparam int          BLOCK_W       = 10;
    localparam int          NUM_BLOCKS    = 1024;
    localparam int          MIN_VALID     = 1004;
    localparam int          CNT_W         = 11;
    localparam logic [7:0]  CMD_STATUS    = 8'h70;
    localparam logic [7:0]  BAD_MARK      = 8'h00;
    localparam logic [7:0]  GOOD_MARK     = 8'hff;
    localparam int          ECC_LIMIT     = 8;
    localparam int          ERR_W         = 4;
    localparam int          UNIT_BYTES    = 528;
    localparam int          STAT_FAIL_BIT = 0;
    localparam int          STAT_RDY1_BIT = 5;
    localparam int          STAT_RDY2_BIT = 6;
    localparam int          STAT_WP_BIT   = 7;
    localparam int          BUSY_CYCLES   = 4;
    localparam logic [2:0]  BUSY_RST      = 3'h0;
endpackage

// ==== tb/flash_host_model.sv ====
// host controller model: block scan, bad-block table, status-checked ops
`timescale 1ns/10ps
module flash_host_model (
    // device side
    input  wire logic       clk,
    input  wire logic [7:0] data_out,
    input  wire logic       data_oe,
    input  wire logic       ready,
    // requests
    output logic            cmd_valid,
    output logic [7:0]      cmd_code,
    output logic            op_start,
    output logic [9:0]      op_block,
    output logic            col_rd,
    output logic [9:0]      col_block
);
    logic bad_q [1024];
    initial {cmd_valid, cmd_code, op_start, op_block, col_rd, col_block} = '0;
    task automatic scan();
        for (int b = 0; b < 1024; b++) begin
            @(negedge clk) {col_rd, col_block} = {1'b1, b[9:0]};
            @(negedge clk) col_rd = 0;
            bad_q[b] = data_oe && data_out == 8'h00;
        end
    endtask
    task automatic op(input int b);
        if (bad_q[b])
            return;
        @(negedge clk) {op_start, op_block} = {1'b1, b[9:0]};
        @(negedge clk) op_start = 0;
        while (!ready) @(negedge clk);
        {cmd_valid, cmd_code} = {1'b1, 8'h70};
        @(negedge clk) cmd_valid = 0;
        repeat (2) @(negedge clk);
        if (ready && data_out[0])
            bad_q[b] = 1;
        {cmd_valid, cmd_code} = 9'h100;
        @(negedge clk) cmd_valid = 0;
        repeat (2) @(negedge clk);
    endtask
endmodule

// ==== tb/tb.sv ====
// self-checking bench for the bad-block and status logic
`timescale 1ns/10ps
module tb;
    logic clk = 0, resetn = 0, mark_we = 0, mark_bad = 0, op_fail = 0;
    logic ecc_valid = 0, wp_n = 1, oe_q = 0;
    logic cmd_valid, op_start, col_rd, data_oe, ready, ecc_uncorr;
    logic [9:0] mark_block = '0, op_block, col_block;
    logic [7:0] col_cell = 8'hff, cmd_code, data_out;
    logic [3:0] ecc_errs = '0;
    logic [10:0] valid_blocks;
    logic bad_set [1024];
    logic [7:0] exp_q [$];
    int failures = 0, comparisons = 0, nb;
    always #10 clk = ~clk;
    nand_bad_block_management i_dut (.clk(clk), .resetn(resetn), .mark_we(mark_we),
        .mark_block(mark_block), .mark_bad(mark_bad), .cmd_valid(cmd_valid),
        .cmd_code(cmd_code), .op_start(op_start), .op_block(op_block), .op_fail(op_fail),
        .col_rd(col_rd), .col_block(col_block), .col_cell(col_cell), .ecc_valid(ecc_valid),
        .ecc_errs(ecc_errs), .wp_n(wp_n), .data_out(data_out), .data_oe(data_oe),
        .ready(ready), .ecc_uncorr(ecc_uncorr), .valid_blocks(valid_blocks));
    flash_host_model i_host (.clk(clk), .data_out(data_out), .data_oe(data_oe),
        .ready(ready), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .op_start(op_start),
        .op_block(op_block), .col_rd(col_rd), .col_block(col_block));
    function automatic int good(int b);
        while (bad_set[b]) b++;
        return b;
    endfunction
    task automatic chk(string nm, logic [10:0] e, logic [10:0] g);
        comparisons++;
        if (g !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic end_of_test();
        $display("failures %0d comparisons %0d", failures, comparisons);
        if (failures == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    always @(negedge clk) begin
        oe_q <= data_oe;
        if (data_oe === 1'b1 && oe_q === 1'b0)
            chk("data_out", exp_q.pop_front(), data_out);
    end
    initial begin
        void'($urandom(32'h4204eca6));
        foreach (bad_set[b]) bad_set[b] = 0;
        for (int i = 0; i < 20; i++) bad_set[i * 51 + $urandom_range(50)] = 1;
        repeat (16) @(negedge clk);
        resetn = 1;
        chk("count", 1024, valid_blocks);
        foreach (bad_set[b]) begin
            {mark_we, mark_block, mark_bad} = {1'b1, 10'(b), bad_set[b]};
            @(negedge clk);
        end
        mark_we = 0;
        @(negedge clk);
        chk("count", 1004, valid_blocks);
        col_cell = 8'($urandom_range(255, 1));
        foreach (bad_set[b]) exp_q.push_back(bad_set[b] ? 8'h00 : col_cell);
        i_host.scan();
        foreach (bad_set[b]) chk("table", bad_set[b], i_host.bad_q[b]);
        nb = good($urandom_range(1000));
        op_fail = 1;
        exp_q.push_back(8'he1);
        i_host.op(nb);
        chk("retired", 1, i_host.bad_q[nb]);
        op_fail = 0;
        exp_q.push_back(8'he0);
        i_host.op(good(nb + 1));
        wp_n = 0;
        repeat (3) @(negedge clk);
        exp_q.push_back(8'h60);
        i_host.op(good(0));
        chk("ready", 1, ready);
        wp_n = 1;
        for (int e = 0; e < 16; e++) begin
            {ecc_valid, ecc_errs} = {1'b1, 4'(e)};
            @(negedge clk) ecc_valid = 0;
            chk("uncorr", e > 8, ecc_uncorr);
        end
        chk("pending", 0, exp_q.size());
        end_of_test();
    end
    initial begin
        #240000;
        failures++;
        end_of_test();
    end
endmodule
